// ===== shared/bfpp_consts.vh
/*
 * Constants for the byte FIFO parallel port: mode codes, widths, depths
 * and timing counts.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef BFPP_CONSTS_VH
`define BFPP_CONSTS_VH

// Port mode codes held in the mode selection input.
`define BFPP_MODE_OFF       2'h0
`define BFPP_MODE_ASYNC     2'h1
`define BFPP_MODE_SYNC      2'h2

// Data path dimensions.
`define BFPP_DATA_W         8
`define BFPP_FIFO_DEPTH     16

// Core clock rate and the output clock rate, both in kHz.
`define BFPP_CLK_KHZ        25000
`define BFPP_FCLK_KHZ       60000
// Half period of the derived output clock in core cycles, at least one.
`define BFPP_FCLK_HALF      ((`BFPP_CLK_KHZ / (2 * `BFPP_FCLK_KHZ)) < 1 ? 1 : \
                             (`BFPP_CLK_KHZ / (2 * `BFPP_FCLK_KHZ)))

`endif

// ===== rtl/bfpp_fifo.v
/*
 * Synchronous FIFO with valid/ready on both sides, flip-flop storage.
 * Assumes a single clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps
module bfpp_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    // Clock and reset.
    input  wire             clk,
    input  wire             nrst,
    // Filling side.
    input  wire             inValid,
    output wire             inReady,
    input  wire [WIDTH-1:0] inData,
    // Draining side.
    output wire             outValid,
    input  wire             outReady,
    output wire [WIDTH-1:0] outData,
    // Control.
    input  wire             flush
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wrPtr_r;
    reg [AW-1:0]    rdPtr_r;
    reg [AW:0]      count_r;
    wire            doWr;
    wire            doRd;

    // Full and empty come from the occupancy count, so neither lies.
    assign inReady  = (count_r != DEPTH[AW:0]);
    assign outValid = (count_r != {(AW+1){1'b0}});
    assign outData  = mem[rdPtr_r];
    assign doWr     = inValid & inReady;
    assign doRd     = outValid & outReady;

    // Pointer and count update; flush empties without touching storage.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wrPtr_r <= {AW{1'b0}};
            rdPtr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
        end else if (flush) begin
            wrPtr_r <= {AW{1'b0}};
            rdPtr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
        end else begin
            if (doWr) begin
                wrPtr_r <= (wrPtr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_r + 1'b1;
            end
            if (doRd) begin
                rdPtr_r <= (rdPtr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_r + 1'b1;
            end
            if (doWr && !doRd) begin
                count_r <= count_r + 1'b1;
            end else if (doRd && !doWr) begin
                count_r <= count_r - 1'b1;
            end
        end
    end

    // Storage has no reset; outData shows a stale slot while empty, and pops wait for outValid.
    always @(posedge clk) begin
        if (doWr) begin
            mem[wrPtr_r] <= inData;
        end
    end

endmodule

// ===== rtl/bfpp_sync3.v
/*
 * Three-stage input synchroniser with agreement filter for a vector of pins.
 * Assumes asynchronous inputs and the core clock domain.
 */
`timescale 1ns/1ps
module bfpp_sync3 #(
    parameter WIDTH   = 1,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b1}}
) (
    // Clock and reset.
    input  wire             clk,
    input  wire             nrst,
    // Raw pins and clean levels.
    input  wire [WIDTH-1:0] pinIn,
    output wire [WIDTH-1:0] level
);

    reg [WIDTH-1:0] st1_r;
    reg [WIDTH-1:0] st2_r;
    reg [WIDTH-1:0] st3_r;
    reg [WIDTH-1:0] level_r;

    assign level = level_r;

    // Stage one is read only by stage two; a change counts once two and three agree.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st1_r   <= RESET_VAL;
            st2_r   <= RESET_VAL;
            st3_r   <= RESET_VAL;
            level_r <= RESET_VAL;
        end else begin
            st1_r <= pinIn;
            st2_r <= st1_r;
            st3_r <= st2_r;
            level_r <= (st2_r & st3_r) | (~(st2_r ^ st3_r) & st3_r) | ((st2_r ^ st3_r) & level_r);
        end
    end

endmodule

// ===== rtl/bfpp_port.v
/*
 * Byte FIFO parallel port, device end. Two channels, each strobe driven
 * (asynchronous) or, channel A only, clocked by a derived output clock.
 * Assumes the USB side offers receive bytes and takes transmit bytes over
 * valid/ready, and that the mode inputs are static configuration.
 */
`timescale 1ns/1ps
`include "bfpp_consts.vh"
module bfpp_port #(
    parameter DW    = `BFPP_DATA_W,
    parameter DEPTH = `BFPP_FIFO_DEPTH
) (
    // Clock and reset.
    input  wire          clk,
    input  wire          nrst,
    // Configuration and USB state.
    input  wire [1:0]    modeA,
    input  wire [1:0]    modeB,
    input  wire          remoteWakeEn,
    input  wire          power_enable_n,
    // Channel A pins.
    input  wire [DW-1:0] chanADataIn,
    output wire [DW-1:0] chanADataOut,
    output wire          chanADataOe,
    output wire          rxAvailANOut,
    output wire          rxAvailANOe,
    output wire          txSpaceANOut,
    output wire          txSpaceANOe,
    input  wire          readStrobeAN,
    input  wire          writeStrobeAN,
    input  wire          outputEnableAN,
    input  wire          send_now_wake_n,
    output wire          fifo_clock_out,
    // Channel B pins.
    input  wire [DW-1:0] chanBDataIn,
    output wire [DW-1:0] chanBDataOut,
    output wire          chanBDataOe,
    output wire          rxAvailBNOut,
    output wire          rxAvailBNOe,
    output wire          txSpaceBNOut,
    output wire          txSpaceBNOe,
    input  wire          readStrobeBN,
    input  wire          writeStrobeBN,
    // USB side, receive direction (host to pins).
    input  wire [2*DW-1:0] usbRxData,
    input  wire [1:0]    usbRxValid,
    output wire [1:0]    usbRxReady,
    // USB side, transmit direction (pins to host).
    output wire [2*DW-1:0] usbTxData,
    output wire [1:0]    usbTxValid,
    input  wire [1:0]    usbTxReady,
    // USB side events.
    output wire          resumeReq,
    output wire          sendNow
);

    localparam AW   = 4;
    localparam HALF = `BFPP_FCLK_HALF;
    // Channel state machine codes.
    localparam ST_IDLE  = 2'h0;
    localparam ST_READ  = 2'h1;
    localparam ST_WRITE = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // Synchronised pins: read, write, output enable, wake (A) and read, write (B).

    wire [5:0] pinLvl;
    bfpp_sync3 #(.WIDTH(6), .RESET_VAL(6'h3F)) uSync (
        .clk   (clk),
        .nrst  (nrst),
        .pinIn ({readStrobeBN, writeStrobeBN, send_now_wake_n, outputEnableAN, writeStrobeAN, readStrobeAN}),
        .level (pinLvl)
    );

    reg [5:0] pinPrev_r;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pinPrev_r <= 6'h3F;
        end else begin
            pinPrev_r <= pinLvl;
        end
    end

    // Edge detection on the filtered levels, so each edge is seen once.
    wire [5:0] fallEdge = pinPrev_r & ~pinLvl;
    wire [5:0] riseEdge = ~pinPrev_r & pinLvl;

    ////////////////////////////////////////////////////////////////////////////
    // Output clock divider; the clocked interface acts on its rising edge.

    reg [7:0] divCnt_r;
    reg       fclk_r;
    reg       fclkRise_r;
    wire      syncMode = (modeA == `BFPP_MODE_SYNC);
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            divCnt_r   <= 8'h00;
            fclk_r     <= 1'b0;
            fclkRise_r <= 1'b0;
        end else if (!syncMode) begin
            divCnt_r   <= 8'h00;
            fclk_r     <= 1'b0;
            fclkRise_r <= 1'b0;
        end else if (divCnt_r == HALF[7:0] - 8'h01) begin
            divCnt_r   <= 8'h00;
            fclk_r     <= ~fclk_r;
            fclkRise_r <= ~fclk_r;
        end else begin
            divCnt_r   <= divCnt_r + 8'h01;
            fclkRise_r <= 1'b0;
        end
    end
    assign fifo_clock_out = fclk_r;

    ////////////////////////////////////////////////////////////////////////////
    // Per-channel datapath: receive and transmit FIFOs and strobe handling.

    wire [DW-1:0] dIn [0:1];
    assign dIn[0] = chanADataIn;
    assign dIn[1] = chanBDataIn;

    reg  [DW-1:0] dOut_r  [0:1];
    reg  [1:0]    dOe_r;
    reg  [1:0]    rxN_r;
    reg  [1:0]    txN_r;
    reg  [1:0]    flagOe_r;
    wire [1:0]    rxFifoValid;
    wire [1:0]    txFifoReady;
    wire [DW-1:0] rxFifoData [0:1];

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : gCh
            wire [1:0] mode   = (ch == 0) ? modeA : ((modeA == `BFPP_MODE_SYNC) ? `BFPP_MODE_OFF : modeB);
            wire       async  = (mode == `BFPP_MODE_ASYNC);
            wire       clocked = (mode == `BFPP_MODE_SYNC);
            wire       rdLvl  = (ch == 0) ? pinLvl[0] : pinLvl[5];
            wire       rdFall = (ch == 0) ? fallEdge[0] : fallEdge[5];
            wire       rdRise = (ch == 0) ? riseEdge[0] : riseEdge[5];
            wire       wrLvl  = (ch == 0) ? pinLvl[1] : pinLvl[4];
            wire       wrFall = (ch == 0) ? fallEdge[1] : fallEdge[4];
            reg  [1:0] state_r;
            reg        rxPop;
            reg        txPush;

            // Asynchronous: pop on read rise; clocked: pop each clock with both lows.
            always @* begin
                rxPop  = 1'b0;
                txPush = 1'b0;
                if (async) begin
                    rxPop  = rdRise && (state_r == ST_READ) && rxFifoValid[ch];
                    txPush = wrFall && !txN_r[ch];
                end else if (clocked) begin
                    rxPop  = fclkRise_r && !rdLvl && !rxN_r[ch];
                    txPush = fclkRise_r && !wrLvl && !txN_r[ch];
                end
            end

            bfpp_fifo #(.WIDTH(DW), .DEPTH(DEPTH), .AW(AW)) uRx (
                .clk      (clk),
                .nrst     (nrst),
                .inValid  (usbRxValid[ch]),
                .inReady  (usbRxReady[ch]),
                .inData   (usbRxData[ch*DW +: DW]),
                .outValid (rxFifoValid[ch]),
                .outReady (rxPop),
                .outData  (rxFifoData[ch]),
                .flush    (1'b0)
            );

            bfpp_fifo #(.WIDTH(DW), .DEPTH(DEPTH), .AW(AW)) uTx (
                .clk      (clk),
                .nrst     (nrst),
                .inValid  (txPush),
                .inReady  (txFifoReady[ch]),
                .inData   (dIn[ch]),
                .outValid (usbTxValid[ch]),
                .outReady (usbTxReady[ch]),
                .outData  (usbTxData[ch*DW +: DW]),
                .flush    (1'b0)
            );

            // Strobe state, flags and bus drive; flags stay released while idle mode.
            always @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    state_r      <= ST_IDLE;
                    rxN_r[ch]    <= 1'b1;
                    txN_r[ch]    <= 1'b1;
                    flagOe_r[ch] <= 1'b0;
                    dOe_r[ch]    <= 1'b0;
                    dOut_r[ch]   <= {DW{1'b0}};
                end else begin
                    flagOe_r[ch] <= async | clocked;
                    txN_r[ch]    <= !txFifoReady[ch] || !(async | clocked);
                    if (async) begin
                        case (state_r)
                            ST_IDLE: begin
                                rxN_r[ch] <= !rxFifoValid[ch];
                                if (rdFall && rxFifoValid[ch]) begin
                                    state_r    <= ST_READ;
                                    dOut_r[ch] <= rxFifoData[ch];
                                    dOe_r[ch]  <= 1'b1;
                                end
                            end
                            ST_READ: begin
                                if (rdRise) begin
                                    state_r   <= ST_WRITE;
                                    rxN_r[ch] <= 1'b1;
                                    dOe_r[ch] <= 1'b0;
                                end
                            end
                            ST_WRITE: begin
                                // One more cycle with the flag high after each read.
                                state_r   <= ST_IDLE;
                                rxN_r[ch] <= 1'b1;
                            end
                            default: begin
                                state_r <= ST_IDLE;
                            end
                        endcase
                    end else if (clocked) begin
                        state_r   <= ST_IDLE;
                        rxN_r[ch] <= !rxFifoValid[ch] || (rxPop && !rdLvl);
                        // The partner owns turn-around; drive only with its enable low.
                        dOe_r[ch] <= !pinLvl[2];
                        if (fclkRise_r || !rdLvl) begin
                            dOut_r[ch] <= rxFifoData[ch];
                        end
                    end else begin
                        state_r   <= ST_IDLE;
                        rxN_r[ch] <= 1'b1;
                        dOe_r[ch] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    assign chanADataOut = dOut_r[0];
    assign chanADataOe  = dOe_r[0];
    assign chanBDataOut = dOut_r[1];
    assign chanBDataOe  = dOe_r[1];
    assign rxAvailANOut = rxN_r[0];
    assign rxAvailANOe  = flagOe_r[0];
    assign rxAvailBNOut = rxN_r[1];
    assign rxAvailBNOe  = flagOe_r[1];
    assign txSpaceANOut = txN_r[0];
    assign txSpaceANOe  = flagOe_r[0];
    assign txSpaceBNOut = txN_r[1];
    assign txSpaceBNOe  = flagOe_r[1];

    ////////////////////////////////////////////////////////////////////////////
    // Send-now and wake: one falling strobe gives at most one pulse, chosen by suspend state; none while suspended without wake enable.
    // A wake input tied high simply never produces an edge.

    reg resume_r;
    reg sendNow_r;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            resume_r  <= 1'b0;
            sendNow_r <= 1'b0;
        end else begin
            resume_r  <= fallEdge[3] && power_enable_n && remoteWakeEn;
            sendNow_r <= fallEdge[3] && !power_enable_n;
        end
    end
    assign resumeReq = resume_r;
    assign sendNow   = sendNow_r;

endmodule

// ===== test/bfpp_port_assertions.sv
/*
 * Concurrent checks on the pins of bfpp_port: channel A strobe mode,
 * channel B disable, the output clock and the send-now event.
 * Assumes it is bound into bfpp_port and uses the mode codes of bfpp_consts.vh.
 */
`timescale 1ns/1ps
`include "bfpp_consts.vh"
module bfpp_port_assertions (
    // Clock, reset and configuration.
    input wire       clk,
    input wire       nrst,
    input wire [1:0] modeA,
    input wire       power_enable_n,
    // Channel A pins.
    input wire       chanADataOe,
    input wire       rxAvailANOut,
    input wire       rxAvailANOe,
    input wire       txSpaceANOut,
    input wire       txSpaceANOe,
    input wire       readStrobeAN,
    input wire       writeStrobeAN,
    input wire       send_now_wake_n,
    input wire       fifo_clock_out,
    // Channel B and USB side.
    input wire       chanBDataOe,
    input wire       rxAvailBNOe,
    input wire [1:0] usbTxValid,
    input wire       sendNow
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////////////////
    // Windows are generous: the strobe synchronisers add four or five cycles.
    property p_flagsOff; modeA == `BFPP_MODE_OFF |-> !rxAvailANOe && !txSpaceANOe; endproperty
    a_flagsOff: assert property (p_flagsOff) else $error("flags driven while off");
    property p_bOff; modeA == `BFPP_MODE_SYNC |-> !chanBDataOe && !rxAvailBNOe; endproperty
    a_bOff: assert property (p_bOff) else $error("channel B active in clocked mode");
    property p_clkOff; modeA != `BFPP_MODE_SYNC |-> !fifo_clock_out; endproperty
    a_clkOff: assert property (p_clkOff) else $error("output clock outside clocked mode");
    property p_oeCause; modeA == `BFPP_MODE_ASYNC && $rose(chanADataOe) |-> !readStrobeAN; endproperty
    a_oeCause: assert property (p_oeCause) else $error("bus driven without read");
    property p_oeEnd; modeA == `BFPP_MODE_ASYNC && readStrobeAN [*8] |-> !chanADataOe; endproperty
    a_oeEnd: assert property (p_oeEnd) else $error("bus still driven after read");
    property p_rxRise; modeA == `BFPP_MODE_ASYNC && $rose(readStrobeAN) |-> ##[2:8] (rxAvailANOut [*2]); endproperty
    a_rxRise: assert property (p_rxRise) else $error("receive flag not raised after read");
    property p_wrTake; modeA == `BFPP_MODE_ASYNC && txSpaceANOe && !txSpaceANOut && $fell(writeStrobeAN)
        |-> ##[2:8] usbTxValid[0]; endproperty
    a_wrTake: assert property (p_wrTake) else $error("written byte not stored");
    property p_sendNow; $fell(send_now_wake_n) && !power_enable_n |-> ##[2:8] sendNow; endproperty
    a_sendNow: assert property (p_sendNow) else $error("send-now not raised");
endmodule

// ===== test/bfpp_host_model.sv
/*
 * Behavioural controller for one strobe channel of the byte FIFO port.
 * Assumes the bench resolves the pulled-up flags and the shared data bus.
 */
`timescale 1ns/1ps
module bfpp_host_model (
    // Clock and resolved pins.
    input  wire       clk,
    input  wire       rxFlagN,
    input  wire       txFlagN,
    input  wire [7:0] busIn,
    // Pins driven by the controller.
    output reg        oeN,
    output reg        readN,
    output reg        writeN,
    output reg  [7:0] dOut,
    output reg        dEn
);
    // Idle pins: strobes and enable high, bus released.
    initial begin
        {oeN, readN, writeN, dEn} = 4'hE;
        dOut = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Pins change only after a falling edge, so the port never sees a race.
    task automatic hold(input logic o, r, w, input logic [7:0] d, input logic e, input int n);
        begin
            @(negedge clk);
            {oeN, readN, writeN, dEn} = {o, r, w, e};
            dOut = d;
            repeat (n - 1) @(negedge clk);
        end
    endtask
    // Writes one byte; obey low ignores a full flag on purpose.
    task automatic wr(input logic [7:0] d, input logic obey);
        int k;
        begin
            for (k = 0; obey && txFlagN !== 1'b0 && k < 400; k++) @(negedge clk);
            hold(1'b1, 1'b1, 1'b1, d, 1'b1, 6);
            hold(1'b1, 1'b1, 1'b0, d, 1'b1, 6);
            hold(1'b1, 1'b1, 1'b1, d, 1'b0, 6);
        end
    endtask
    // Reads one byte once the receive flag shows data waiting.
    task automatic rd(output logic [7:0] d);
        int k;
        begin
            for (k = 0; rxFlagN !== 1'b0 && k < 400; k++) @(negedge clk);
            hold(1'b1, 1'b0, 1'b1, dOut, 1'b0, 8);
            d = busIn;
            hold(1'b1, 1'b1, 1'b1, dOut, 1'b0, 8);
        end
    endtask
endmodule

// ===== test/test_byte_fifo_parallel_port.sv
/*
 * Self-checking bench for bfpp_port: strobe transfers on both channels,
 * full buffers, wake events and the clocked mode of channel A.
 * Assumes bfpp_host_model on each channel and the bound checker.
 */
`timescale 1ns/1ps
`include "bfpp_consts.vh"
module test_byte_fifo_parallel_port;
    reg         clk, nrst, remoteWakeEn, power_enable_n, send_now_wake_n;
    reg  [1:0]  modeA, modeB, usbRxValid, usbTxReady;
    reg  [15:0] usbRxData;
    wire [15:0] usbTxData;
    wire [7:0]  chanADataOut, chanBDataOut, aD, bD, busA, busB;
    wire [1:0]  usbRxReady, usbTxValid;
    wire        chanADataOe, rxAvailANOut, rxAvailANOe, txSpaceANOut, txSpaceANOe, aEn, aRd, aWr, aOe;
    wire        chanBDataOe, rxAvailBNOut, rxAvailBNOe, txSpaceBNOut, txSpaceBNOe, bEn, bRd, bWr;
    wire        fifo_clock_out, resumeReq, sendNow, rxA, txA, rxB, txB;
    int         fails, n_checks, nRes, nSnd;
    // Pull-ups on the flags; a released bus shows the inverse of the controller's data.
    assign rxA  = rxAvailANOe ? rxAvailANOut : 1'b1;
    assign txA  = txSpaceANOe ? txSpaceANOut : 1'b1;
    assign rxB  = rxAvailBNOe ? rxAvailBNOut : 1'b1;
    assign txB  = txSpaceBNOe ? txSpaceBNOut : 1'b1;
    assign busA = chanADataOe ? chanADataOut : (aEn ? aD : ~aD);
    assign busB = chanBDataOe ? chanBDataOut : (bEn ? bD : ~bD);
    bfpp_port dut (.clk(clk), .nrst(nrst), .modeA(modeA), .modeB(modeB), .remoteWakeEn(remoteWakeEn),
        .power_enable_n(power_enable_n), .chanADataIn(busA), .chanADataOut(chanADataOut),
        .chanADataOe(chanADataOe), .rxAvailANOut(rxAvailANOut), .rxAvailANOe(rxAvailANOe),
        .txSpaceANOut(txSpaceANOut), .txSpaceANOe(txSpaceANOe), .readStrobeAN(aRd), .writeStrobeAN(aWr),
        .outputEnableAN(aOe), .send_now_wake_n(send_now_wake_n), .fifo_clock_out(fifo_clock_out),
        .chanBDataIn(busB), .chanBDataOut(chanBDataOut), .chanBDataOe(chanBDataOe),
        .rxAvailBNOut(rxAvailBNOut), .rxAvailBNOe(rxAvailBNOe), .txSpaceBNOut(txSpaceBNOut),
        .txSpaceBNOe(txSpaceBNOe), .readStrobeBN(bRd), .writeStrobeBN(bWr), .usbRxData(usbRxData),
        .usbRxValid(usbRxValid), .usbRxReady(usbRxReady), .usbTxData(usbTxData), .usbTxValid(usbTxValid),
        .usbTxReady(usbTxReady), .resumeReq(resumeReq), .sendNow(sendNow));
    bfpp_host_model hA (.clk(clk), .rxFlagN(rxA), .txFlagN(txA), .busIn(busA), .oeN(aOe), .readN(aRd),
        .writeN(aWr), .dOut(aD), .dEn(aEn));
    bfpp_host_model hB (.clk(clk), .rxFlagN(rxB), .txFlagN(txB), .busIn(busB), .oeN(), .readN(bRd),
        .writeN(bWr), .dOut(bD), .dEn(bEn));
    // Core clock at 25 MHz.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Event pulses are counted so that a doubled pulse shows up.
    always @(posedge clk) begin
        nRes <= nRes + resumeReq;
        nSnd <= nSnd + sendNow;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] a, input logic [7:0] e);
        begin
            n_checks++;
            if (a !== e) begin
                fails++;
                $display("[FAIL] t=%0t got %h exp %h", $time, a, e);
            end
        end
    endtask
    task automatic end_of_test;
        begin
            $display("Checks %0d, mismatches %0d", n_checks, fails);
            if (fails == 0 && n_checks > 0) begin
                $display("Regression OK");
            end else begin
                $display("Regression broken");
            end
            $finish;
        end
    endtask
    // Holds reset six cycles with the new modes; flags must float high meanwhile.
    task automatic do_reset(input logic [1:0] ma, input logic [1:0] mb);
        begin
            @(negedge clk);
            nrst = 1'b0;
            modeA = ma;
            modeB = mb;
            repeat (6) @(negedge clk);
            chk({4'h0, rxA, txA, rxB, txB}, 8'h0F);
            nrst = 1'b1;
            repeat (8) @(negedge clk);
        end
    endtask
    // Offers one byte from the USB side; held until the port is ready.
    task automatic push(input int ch, input logic [7:0] d);
        int k;
        begin
            @(negedge clk);
            usbRxData[ch*8 +: 8] = d;
            usbRxValid[ch] = 1'b1;
            for (k = 0; usbRxReady[ch] !== 1'b1 && k < 50; k++) @(negedge clk);
            @(negedge clk);
            usbRxValid[ch] = 1'b0;
        end
    endtask
    // Takes one byte towards USB and compares it.
    task automatic take(input int ch, input logic [7:0] e);
        int k;
        begin
            @(negedge clk);
            for (k = 0; usbTxValid[ch] !== 1'b1 && k < 50; k++) @(negedge clk);
            chk(usbTxData[ch*8 +: 8], e);
            usbTxReady[ch] = 1'b1;
            @(negedge clk);
            usbTxReady[ch] = 1'b0;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Fills the transmit buffer with USB stalled, tries one more, then drains.
    task automatic t_write;
        int i;
        begin
            do_reset(`BFPP_MODE_ASYNC, `BFPP_MODE_OFF);
            chk({7'h00, txA}, 8'h00);
            for (i = 0; i < 16; i++) hA.wr(8'h10 + i[7:0], 1'b1);
            chk({7'h00, txA}, 8'h01);
            hA.wr(8'hEE, 1'b0);
            for (i = 0; i < 16; i++) take(0, 8'h10 + i[7:0]);
            repeat (4) @(negedge clk);
            chk({7'h00, usbTxValid[0]}, 8'h00);
        end
    endtask
    // Fills the receive buffer until refused, then reads every byte back.
    task automatic t_read;
        int i;
        logic [7:0] d;
        begin
            do_reset(`BFPP_MODE_ASYNC, `BFPP_MODE_OFF);
            chk({7'h00, rxA}, 8'h01);
            for (i = 0; i < 16; i++) push(0, 8'hA0 + i[7:0]);
            chk({6'h00, usbRxReady[0], rxA}, 8'h00);
            for (i = 0; i < 16; i++) begin
                hA.rd(d);
                chk(d, 8'hA0 + i[7:0]);
            end
            chk({6'h00, rxA, chanADataOe}, 8'h02);
        end
    endtask
    // Channel B alone in strobe mode, channel A off.
    task automatic t_chan_b;
        logic [7:0] d;
        begin
            do_reset(`BFPP_MODE_OFF, `BFPP_MODE_ASYNC);
            hB.wr(8'h3C, 1'b1);
            take(1, 8'h3C);
            push(1, 8'hC5);
            hB.rd(d);
            chk(d, 8'hC5);
        end
    endtask
    // Wake strobe while awake, suspended with wake allowed, suspended without.
    task automatic t_wake;
        int i, r, s;
        begin
            do_reset(`BFPP_MODE_ASYNC, `BFPP_MODE_OFF);
            for (i = 0; i < 3; i++) begin
                power_enable_n = (i != 0);
                remoteWakeEn = (i != 2);
                // The pulse counters have one driver; the bench only takes differences.
                r = nRes;
                s = nSnd;
                send_now_wake_n = 1'b0;
                repeat (6) @(negedge clk);
                send_now_wake_n = 1'b1;
                repeat (10) @(negedge clk);
                r = nRes - r;
                s = nSnd - s;
                chk({r[3:0], s[3:0]}, {3'h0, i == 1, 3'h0, i == 0});
            end
        end
    endtask
    // Clocked mode: B disabled, clock running, a held write and an enabled read.
    task automatic t_sync;
        logic c;
        int i;
        begin
            do_reset(`BFPP_MODE_SYNC, `BFPP_MODE_ASYNC);
            chk({6'h00, rxB, txB}, 8'h03);
            c = fifo_clock_out;
            @(negedge clk);
            chk({7'h00, fifo_clock_out}, {7'h00, ~c});
            hA.hold(1'b1, 1'b1, 1'b0, 8'h5A, 1'b1, 8);
            // Data stays driven until the synchronised strobe has risen.
            hA.hold(1'b1, 1'b1, 1'b1, 8'h5A, 1'b1, 6);
            // Eight core cycles low span four output-clock rises, one byte each.
            for (i = 0; i < 4; i++) take(0, 8'h5A);
            chk({7'h00, usbTxValid[0]}, 8'h00);
            push(0, 8'hC3);
            hA.hold(1'b0, 1'b1, 1'b1, 8'h00, 1'b0, 8);
            chk(busA, 8'hC3);
            hA.hold(1'b0, 1'b0, 1'b1, 8'h00, 1'b0, 6);
            hA.hold(1'b1, 1'b1, 1'b1, 8'h00, 1'b0, 6);
            chk({6'h00, rxA, chanADataOe}, 8'h02);
        end
    endtask
    // Main sequence, starting in reset with every input at a known level.
    initial begin
        {nrst, modeA, modeB, usbRxValid, usbTxReady, usbRxData} = 25'h0000000;
        {remoteWakeEn, power_enable_n, send_now_wake_n} = 3'h5;
        {fails, n_checks} = 64'h0;
        t_write;
        t_read;
        t_chan_b;
        t_wake;
        t_sync;
        end_of_test;
    end
    // Watchdog: the scenarios need well under 20000 cycles.
    initial begin
        #800000;
        fails++;
        end_of_test;
    end
endmodule
bind bfpp_port bfpp_port_assertions u_chk (.clk(clk), .nrst(nrst), .modeA(modeA),
    .power_enable_n(power_enable_n), .chanADataOe(chanADataOe), .rxAvailANOut(rxAvailANOut),
    .rxAvailANOe(rxAvailANOe), .txSpaceANOut(txSpaceANOut), .txSpaceANOe(txSpaceANOe),
    .readStrobeAN(readStrobeAN), .writeStrobeAN(writeStrobeAN), .send_now_wake_n(send_now_wake_n),
    .fifo_clock_out(fifo_clock_out), .chanBDataOe(chanBDataOe), .rxAvailBNOe(rxAvailBNOe),
    .usbTxValid(usbTxValid), .sendNow(sendNow));
